// >>> dv/mbr_mem_model.sv
// Stream-out buffer model: answers the memory write port and files records.
// Assumes one record of SO_REC_BYTES bytes per macroblock, word 0 first, words 4 bytes apart.
`timescale 1ns/1ps
`default_nettype none
module mbr_mem_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        slow_i,
	input  wire logic [31:0] base_i,
	input  wire logic        mem_valid_i,
	input  wire logic [31:0] mem_addr_i,
	input  wire logic [31:0] mem_data_i,
	output logic             mem_ready_o
);
	logic [31:0] rec_w0 [0:15];
	logic [31:0] exp_addr;
	logic [31:0] rec_idx;
	int          beat = 0;
	int          bad = 0;
	// Consumer view: slot found from base offset alone
	assign rec_idx = (mem_addr_i - base_i) / mbr_pkg::SO_REC_BYTES;
	always @(posedge clk_i) begin
		if (rst_i) begin
			mem_ready_o <= 1'b0;
			beat <= 0;
		end else begin
			// Busy memory: stalls every other cycle
			mem_ready_o <= slow_i ? ~mem_ready_o : 1'b1;
			if (mem_valid_i && mem_ready_o) begin
				if (beat == 0) begin
					rec_w0[rec_idx[3:0]] <= mem_data_i;
					exp_addr = mem_addr_i;
				end else if (mem_data_i !== 32'h0 || mem_addr_i !== exp_addr + 32'(beat * 4)) begin
					bad <= bad + 1;
				end
				beat <= (beat == 15) ? 0 : beat + 1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> dv/tb_mb_inline_record_and_streamout.sv
// Self-checking bench: random record words, Wishbone setup, stream-out records.
// Assumes mbr_core with a one-cycle unpack flop and a 16-word record.
`timescale 1ns/1ps
`default_nettype none
module tb_mb_inline_record_and_streamout;
	logic        clk_i = 1'b0, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, vc1_mode_i, so_valid_i, so_ready_o, slow;
	logic        xform_size_flag_i, field_mb_flag_i, intra_flag_i, mem_valid_o, mem_ready_i, wb_ack_o;
	logic        l8, lu, ll, ta, tr, tl;
	logic [1:0]  chroma_intra_selector_o, intra_mb_kind_i;
	logic [2:0]  mv_layout_format_i, coded_dc_pattern_i;
	logic [3:0]  wb_sel_i;
	logic [4:0]  mb_type_short_i;
	logic [7:0]  wb_adr_i, avail_byte_i, chroma_xform_types_o, shp_o, luma_o, fok_o, packed_mv_count_i;
	logic [11:0] pk_o;
	logic [15:0] pw_o, ph_o, b0_o, b1_o;
	logic [31:0] wb_dat_i, wb_dat_o, inter_w4_i, inter_w5_i, inter_w6_i, mem_addr_o, mem_data_o;
	logic [31:0] seed, q, a, w4, w5, w6, base;
	logic [31:0] w0 [0:3];
	int          error_cnt = 0, n_checks = 0, t;
	always #25 clk_i = ~clk_i;
	mbr_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.avail_byte_i(avail_byte_i), .inter_w4_i(inter_w4_i), .inter_w5_i(inter_w5_i), .inter_w6_i(inter_w6_i),
		.vc1_mode_i(vc1_mode_i), .left_row8_avail_o(l8), .left_upper_avail_o(lu), .left_lower_avail_o(ll),
		.top_avail_o(ta), .top_right_avail_o(tr), .top_left_avail_o(tl),
		.chroma_intra_selector_o(chroma_intra_selector_o), .chroma_xform_types_o(chroma_xform_types_o),
		.subblock_pred_kind_o(pk_o), .subblock_partition_shapes_o(shp_o), .luma_xform_types_o(luma_o),
		.partition_width_o(pw_o), .partition_height_o(ph_o), .list0_bind_index_o(b0_o),
		.list1_bind_index_o(b1_o), .ref_format_ok_o(fok_o), .so_valid_i(so_valid_i), .so_ready_o(so_ready_o),
		.packed_mv_count_i(packed_mv_count_i), .mv_layout_format_i(mv_layout_format_i),
		.coded_dc_pattern_i(coded_dc_pattern_i), .xform_size_flag_i(xform_size_flag_i),
		.field_mb_flag_i(field_mb_flag_i), .intra_flag_i(intra_flag_i), .mb_type_short_i(mb_type_short_i),
		.intra_mb_kind_i(intra_mb_kind_i), .mem_valid_o(mem_valid_o), .mem_ready_i(mem_ready_i),
		.mem_addr_o(mem_addr_o), .mem_data_o(mem_data_o));
	mbr_mem_model i_mem (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .base_i(base), .mem_valid_i(mem_valid_o),
		.mem_addr_i(mem_addr_o), .mem_data_i(mem_data_o), .mem_ready_o(mem_ready_i));
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	function automatic logic [11:0] pk(input logic [7:0] m, input logic v);
		for (int b = 0; b < 4; b++)
			pk[3*b+:3] = (m[2*b+:2] == 2'h3) ? (v ? 3'(mbr_pkg::MBR_PM_INTRA) : 3'(mbr_pkg::MBR_PM_DIRECT))
				: {1'b0, m[2*b+:2]};
	endfunction
	function automatic logic [31:0] wh(input logic [7:0] s);
		for (int b = 0; b < 4; b++) begin
			wh[16+4*b+:4] = s[2*b+1] ? 4'h4 : 4'h8;
			wh[4*b+:4] = s[2*b] ? 4'h4 : 4'h8;
		end
	endfunction
	function automatic logic [19:0] rf(input logic [31:0] w);
		for (int b = 0; b < 4; b++) begin
			rf[4*b+:4] = w[8*b+1+:4];
			rf[16+b] = w[8*b+7] & (w[8*b+5+:2] == 2'h0);
		end
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (wb_ack_o !== 1'b1 && t < 50);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (t >= 50) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask
	task automatic so_send(input logic [31:0] r, output logic [31:0] e);
		@(posedge clk_i);
		{packed_mv_count_i, mv_layout_format_i, coded_dc_pattern_i} <= {r[31:24], r[22:17]};
		{xform_size_flag_i, field_mb_flag_i, intra_flag_i, mb_type_short_i} <= r[15:8];
		intra_mb_kind_i <= r[5:4];
		so_valid_i <= 1'b1;
		e = r & 32'hFF7EFF30;
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (so_ready_o !== 1'b1 && t < 300);
		so_valid_i <= 1'b0;
		if (t >= 300) begin
			error_cnt++;
			tally_and_finish();
		end
	endtask
	initial begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, vc1_mode_i, so_valid_i, slow, wb_sel_i} = {7'h41, 4'hF};
		{wb_adr_i, wb_dat_i, avail_byte_i, inter_w4_i, inter_w5_i, inter_w6_i} = '0;
		{packed_mv_count_i, mv_layout_format_i, coded_dc_pattern_i, xform_size_flag_i} = '0;
		{field_mb_flag_i, intra_flag_i, mb_type_short_i, intra_mb_kind_i} = '0;
		seed = 32'hB2B9;
		base = 32'h0;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b0, mbr_pkg::REG_BASE, 32'h0);
		chk(q, mbr_pkg::BASE_RST);
		bus(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		chk(32'(so_ready_o), 32'h0);
		for (int i = 0; i < 24; i++) begin
			a = rnd();
			w4 = (i < 2) ? 32'hFFFFFFFF : rnd(); // the first two records stand for BP_8x8 macroblocks, the rest take random word 4
			w5 = (i == 0) ? 32'h9F80A0C1 : rnd();
			w6 = i[0] ? (rnd() | 32'h80808080) & 32'h9F9F9F9F : rnd();
			@(posedge clk_i);
			{avail_byte_i, vc1_mode_i} <= {a[7:0], a[8] ^ (i == 1)};
			{inter_w4_i, inter_w5_i, inter_w6_i} <= {w4, w5, w6};
			repeat (2) @(posedge clk_i);
			#1;
			a[8] = a[8] ^ (i == 1);
			chk(32'({l8, lu, ll, ta, tr, tl, chroma_intra_selector_o}), 32'(a[7:0]));
			chk(32'(chroma_xform_types_o), a[8] ? 32'(w4[23:16]) : 32'h0);
			chk(32'(pk_o), 32'(pk(w4[15:8], a[8])));
			chk(32'({luma_o, shp_o}), a[8] ? 32'({w4[7:0], 8'h0}) : 32'(w4[7:0]));
			if (!a[8])
				chk({pw_o, ph_o}, wh(w4[7:0]));
			chk(32'({fok_o[3:0], b0_o}), 32'(rf(w5)));
			chk(32'({fok_o[7:4], b1_o}), 32'(rf(w6)));
		end
		base = rnd() & 32'hFFFFFFFC;
		bus(1'b1, mbr_pkg::REG_BASE, base);
		bus(1'b1, mbr_pkg::REG_CTRL, 32'h1);
		for (int k = 0; k < 4; k++) begin
			slow <= k[0];
			so_send(rnd(), w0[k]);
		end
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (so_ready_o !== 1'b1 && t < 300);
		if (t >= 300)
			error_cnt++;
		for (int k = 0; k < 4; k++)
			chk(i_mem.rec_w0[k] & 32'hFFFFFFF0, w0[k]);
		chk(32'(i_mem.bad), 32'h0);
		bus(1'b0, mbr_pkg::REG_MBCOUNT, 32'h0);
		chk(q, 32'h4);
		{inter_w5_i, inter_w6_i} <= {2{32'h80808080}};
		bus(1'b1, mbr_pkg::REG_STATUS, 32'h2);
		bus(1'b0, mbr_pkg::REG_STATUS, 32'h0);
		chk(q, 32'h0);
		bus(1'b1, mbr_pkg::REG_CTRL, 32'h2);
		bus(1'b0, mbr_pkg::REG_MBCOUNT, 32'h0);
		chk(q, 32'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire

// >>> hw/mbr_core.sv
// Inline record unpack and per-macroblock stream-out record pack.
// Assumes a classic Wishbone master for registers and a memory port that stalls by ready.
`timescale 1ns/1ps
`default_nettype none
module mbr_core (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// Inline record words
	input  wire logic [7:0]  avail_byte_i,
	input  wire logic [31:0] inter_w4_i,
	input  wire logic [31:0] inter_w5_i,
	input  wire logic [31:0] inter_w6_i,
	input  wire logic        vc1_mode_i,
	output logic             left_row8_avail_o,
	output logic             left_upper_avail_o,
	output logic             left_lower_avail_o,
	output logic             top_avail_o,
	output logic             top_right_avail_o,
	output logic             top_left_avail_o,
	output logic      [1:0]  chroma_intra_selector_o,
	output logic      [7:0]  chroma_xform_types_o,
	output logic      [11:0] subblock_pred_kind_o,
	output logic      [7:0]  subblock_partition_shapes_o,
	output logic      [7:0]  luma_xform_types_o,
	output logic      [15:0] partition_width_o,
	output logic      [15:0] partition_height_o,
	output logic      [15:0] list0_bind_index_o,
	output logic      [15:0] list1_bind_index_o,
	output logic      [7:0]  ref_format_ok_o,
	// Per-macroblock stream-out request
	input  wire logic        so_valid_i,
	output logic             so_ready_o,
	input  wire logic [7:0]  packed_mv_count_i,
	input  wire logic [2:0]  mv_layout_format_i,
	input  wire logic [2:0]  coded_dc_pattern_i,
	input  wire logic        xform_size_flag_i,
	input  wire logic        field_mb_flag_i,
	input  wire logic        intra_flag_i,
	input  wire logic [4:0]  mb_type_short_i,
	input  wire logic [1:0]  intra_mb_kind_i,
	// Memory write port
	output logic             mem_valid_o,
	input  wire logic        mem_ready_i,
	output logic      [31:0] mem_addr_o,
	output logic      [31:0] mem_data_o
);
	// Unpack: registered so data outputs come from flip-flops
	logic [7:0]  av_r;
	logic [31:0] w4_r;
	logic [31:0] w5_r;
	logic [31:0] w6_r;
	logic        vc1_r;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			av_r  <= 8'h00;
			w4_r  <= 32'h00000000;
			w5_r  <= 32'h00000000;
			w6_r  <= 32'h00000000;
			vc1_r <= 1'b0;
		end else begin
			av_r  <= avail_byte_i;
			w4_r  <= inter_w4_i;
			w5_r  <= inter_w5_i;
			w6_r  <= inter_w6_i;
			vc1_r <= vc1_mode_i;
		end
	end

	assign left_row8_avail_o  = av_r[mbr_pkg::AV_LEFT_ROW8];
	assign left_upper_avail_o = av_r[mbr_pkg::AV_LEFT_UPPER];
	assign left_lower_avail_o = av_r[mbr_pkg::AV_LEFT_LOWER];
	assign top_avail_o        = av_r[mbr_pkg::AV_TOP];
	assign top_right_avail_o  = av_r[mbr_pkg::AV_TOP_RIGHT];
	assign top_left_avail_o   = av_r[mbr_pkg::AV_TOP_LEFT];
	assign chroma_intra_selector_o = av_r[mbr_pkg::AV_CHROMA_LSB +: 2];
	// Outside VC-1 the producer writes zero here; forced to zero anyway
	assign chroma_xform_types_o = vc1_r ? w4_r[mbr_pkg::W4_UV_LSB +: 8] : 8'h00;
	// Shapes pass unchanged outside VC-1 and read zero in VC-1; producer zeroes them for non-BP_8x8
	assign subblock_partition_shapes_o = vc1_r ? 8'h00 : w4_r[mbr_pkg::W4_SHAPE_LSB +: 8];
	assign luma_xform_types_o = vc1_r ? w4_r[mbr_pkg::W4_SHAPE_LSB +: 8] : 8'h00;

	genvar b;
	generate
		for (b = 0; b < 4; b++) begin : g_blk
			wire logic [1:0] pm = w4_r[mbr_pkg::W4_PRED_LSB + 2*b +: 2];
			wire logic [1:0] sh = w4_r[mbr_pkg::W4_SHAPE_LSB + 2*b +: 2];
			mbr_pkg::mbr_pred_e kind;
			always_comb begin
				case (pm)
					mbr_pkg::PM_L0: kind = mbr_pkg::MBR_PM_LIST0;
					mbr_pkg::PM_L1: kind = mbr_pkg::MBR_PM_LIST1;
					mbr_pkg::PM_BI: kind = mbr_pkg::MBR_PM_BI;
					default:        kind = vc1_r ? mbr_pkg::MBR_PM_INTRA : mbr_pkg::MBR_PM_DIRECT;
				endcase
			end
			assign subblock_pred_kind_o[3*b +: 3] = kind;
			// Bit 1 narrows width, bit 0 narrows height
			assign partition_width_o[4*b +: 4]  = sh[1] ? 4'h4 : 4'h8;
			assign partition_height_o[4*b +: 4] = sh[0] ? 4'h4 : 4'h8;
			wire logic [7:0] r0 = w5_r[8*b +: 8];
			wire logic [7:0] r1 = w6_r[8*b +: 8];
			assign list0_bind_index_o[4*b +: 4] = r0[mbr_pkg::REF_BTI_LSB +: 4];
			assign list1_bind_index_o[4*b +: 4] = r1[mbr_pkg::REF_BTI_LSB +: 4];
			// Flags a byte that meets the frame-store format contract
			assign ref_format_ok_o[b]     = r0[mbr_pkg::REF_FMT_BIT] & (r0[6:5] == 2'h0);
			assign ref_format_ok_o[b + 4] = r1[mbr_pkg::REF_FMT_BIT] & (r1[6:5] == 2'h0);
		end
	endgenerate

	// Registers
	logic [1:0]  ctrl_r;
	logic [31:0] base_r;
	logic [31:0] mb_idx_r;
	logic        ack_r;
	logic        fmt_err_r;
	wire  logic  so_en   = ctrl_r[0];
	wire  logic  idx_clr = ctrl_r[1];
	wire  logic  wb_req  = wb_cyc_i & wb_stb_i & ~ack_r;
	wire  logic  wb_wr   = wb_req & wb_we_i;
	wire  logic  hit_ctrl = wb_adr_i == mbr_pkg::REG_CTRL;
	wire  logic  hit_base = wb_adr_i == mbr_pkg::REG_BASE;
	wire  logic  hit_stat = wb_adr_i == mbr_pkg::REG_STATUS;
	wire  logic  hit_cnt  = wb_adr_i == mbr_pkg::REG_MBCOUNT;
	wire  logic [31:0] sel_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	wire  logic [31:0] base_nxt = (base_r & ~sel_mask) | (wb_dat_i & sel_mask);
	mbr_pkg::mbr_state_e state_r;
	wire  logic  busy = state_r == mbr_pkg::MBR_WRITE;
	wire  logic [31:0] rd_mux = hit_ctrl ? {30'h0, ctrl_r} :
	                            hit_base ? base_r :
	                            hit_stat ? {30'h0, fmt_err_r, busy} :
	                            hit_cnt  ? mb_idx_r : 32'h00000000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r    <= 1'b0;
			wb_dat_o <= 32'h00000000;
			ctrl_r   <= mbr_pkg::CTRL_RST;
			base_r   <= mbr_pkg::BASE_RST;
		end else begin
			ack_r    <= wb_req;
			wb_dat_o <= wb_req ? rd_mux : wb_dat_o;
			if (wb_wr && hit_ctrl && wb_sel_i[0])
				ctrl_r <= wb_dat_i[1:0];
			else
				ctrl_r[1] <= 1'b0;
			if (wb_wr && hit_base)
				base_r <= base_nxt;
		end
	end
	assign wb_ack_o = ack_r;

	// Sticky format error, set wins over write-one clear
	wire logic fmt_bad = ~(&ref_format_ok_o);
	wire logic fmt_clr = wb_wr & hit_stat & wb_sel_i[0] & wb_dat_i[1];
	always_ff @(posedge clk_i) begin
		if (rst_i)
			fmt_err_r <= 1'b0;
		else
			fmt_err_r <= fmt_bad | (fmt_err_r & ~fmt_clr);
	end

	// Stream-out packer
	logic [3:0]  word_r;
	logic [31:0] w0_r;
	wire  logic [31:0] w0_nxt = {packed_mv_count_i, 1'b0, mv_layout_format_i, coded_dc_pattern_i, 1'b0,
	                             xform_size_flag_i, field_mb_flag_i, intra_flag_i,
	                             mb_type_short_i, 2'b00, intra_mb_kind_i, 4'h0};
	// Index times record size, record size a power of two in practice
	wire  logic [31:0] rec_off  = mb_idx_r * mbr_pkg::SO_REC_BYTES;
	wire  logic        take     = so_valid_i & so_en & ~busy;
	wire  logic        beat     = busy & mem_ready_i;
	wire  logic        last     = beat & (word_r == mbr_pkg::SO_REC_WORDS);
	// Every accepted macroblock gets a whole record; none is dropped
	assign so_ready_o  = so_en & ~busy;
	assign mem_valid_o = busy;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r    <= mbr_pkg::MBR_IDLE;
			word_r     <= 4'h0;
			w0_r       <= 32'h00000000;
			mb_idx_r   <= 32'h00000000;
			mem_addr_o <= 32'h00000000;
			mem_data_o <= 32'h00000000;
		end else begin
			case (state_r)
				mbr_pkg::MBR_IDLE: begin
					if (idx_clr)
						mb_idx_r <= 32'h00000000;
					if (take) begin
						state_r    <= mbr_pkg::MBR_WRITE;
						word_r     <= 4'h0;
						w0_r       <= w0_nxt;
						mem_addr_o <= base_r + rec_off;
						mem_data_o <= w0_nxt;
					end
				end
				mbr_pkg::MBR_WRITE: begin
					if (beat) begin
						word_r     <= word_r + 4'h1;
						mem_addr_o <= mem_addr_o + 32'h00000004;
						// Fields past word 0 are not produced here and write as zero
						mem_data_o <= 32'h00000000;
					end
					if (last) begin
						state_r  <= mbr_pkg::MBR_IDLE;
						mb_idx_r <= mb_idx_r + 32'h00000001;
					end
				end
				default: state_r <= mbr_pkg::MBR_IDLE;
			endcase
		end
	end

	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	left_halves_a: assert property (
		1'b1 |=>
		{left_upper_avail_o, left_lower_avail_o} == $past(avail_byte_i[6:5]))
		else $error("left halves wrong");
	top_pair_a: assert property (
		1'b1 |=>
		{top_right_avail_o, top_left_avail_o} == $past(avail_byte_i[3:2]))
		else $error("top pair wrong");
	uv_xform_a: assert property (
		vc1_r |->
		chroma_xform_types_o == w4_r[23:16])
		else $error("chroma transform wrong");
	uv_zero_a: assert property (
		!vc1_r |->
		chroma_xform_types_o == 8'h00)
		else $error("chroma transform not zero");
	pred_direct_a: assert property (
		!vc1_r && w4_r[15:14] == 2'h3 |->
		subblock_pred_kind_o[11:9] == mbr_pkg::MBR_PM_DIRECT)
		else $error("direct decode wrong");
	pred_list1_a: assert property (
		w4_r[11:10] == mbr_pkg::PM_L1 |->
		subblock_pred_kind_o[5:3] == mbr_pkg::MBR_PM_LIST1)
		else $error("list1 decode wrong");
	pred_bi_a: assert property (
		w4_r[13:12] == mbr_pkg::PM_BI |->
		subblock_pred_kind_o[8:6] == mbr_pkg::MBR_PM_BI)
		else $error("bi decode wrong");
	pred_list0_a: assert property (
		w4_r[9:8] == mbr_pkg::PM_L0 |->
		subblock_pred_kind_o[2:0] == mbr_pkg::MBR_PM_LIST0)
		else $error("list0 decode wrong");
	shape_pass_a: assert property (
		!vc1_r |->
		subblock_partition_shapes_o == w4_r[7:0])
		else $error("shapes wrong");
	luma_xform_a: assert property (
		vc1_r |->
		luma_xform_types_o == w4_r[7:0] && subblock_partition_shapes_o == 8'h00)
		else $error("luma transform wrong");
	luma_zero_a: assert property (
		!vc1_r |->
		luma_xform_types_o == 8'h00)
		else $error("luma transform not zero");
	narrow_wide_a: assert property (
		w4_r[7:6] == 2'h2 |->
		partition_width_o[15:12] == 4'h4 && partition_height_o[15:12] == 4'h8)
		else $error("4x8 decode wrong");
	narrow_high_a: assert property (
		w4_r[3:2] == 2'h1 |->
		partition_width_o[7:4] == 4'h8 && partition_height_o[7:4] == 4'h4)
		else $error("8x4 decode wrong");
	full_block_a: assert property (
		w4_r[1:0] == 2'h0 |->
		partition_width_o[3:0] == 4'h8 && partition_height_o[3:0] == 4'h8)
		else $error("8x8 decode wrong");
	list0_bytes_a: assert property (
		1'b1 |=>
		list0_bind_index_o[15:12] == $past(inter_w5_i[28:25]) && list0_bind_index_o[3:0] == $past(inter_w5_i[4:1]))
		else $error("list0 index wrong");
	list1_low_a: assert property (
		1'b1 |=>
		list1_bind_index_o[3:0] == $past(inter_w6_i[4:1]))
		else $error("list1 index wrong");
	ref_format_a: assert property (
		!w5_r[31] |->
		!ref_format_ok_o[3])
		else $error("index format passed");
	ref_mbz_a: assert property (
		w6_r[6:5] != 2'h0 |->
		!ref_format_ok_o[4])
		else $error("reserved bits passed");
	fmt_sticky_a: assert property (
		fmt_bad |=>
		fmt_err_r)
		else $error("format error lost");
	beat_hold_a: assert property (
		busy && !mem_ready_i |=>
		mem_valid_o && $stable(mem_addr_o) && $stable(mem_data_o))
		else $error("beat not held");
	beat_step_a: assert property (
		beat && !last |=>
		mem_addr_o == $past(mem_addr_o) + 32'h00000004)
		else $error("beat address step wrong");
	zero_words_a: assert property (
		beat |=>
		mem_data_o == 32'h00000000)
		else $error("later word not zero");
	ready_gate_a: assert property (
		!so_en |->
		!so_ready_o)
		else $error("ready while disabled");
	idle_quiet_a: assert property (
		!busy |->
		!mem_valid_o)
		else $error("write while idle");
	take_go_a: assert property (
		take |=>
		busy && mem_valid_o)
		else $error("record not started");
	idx_hold_a: assert property (
		busy && !last |=>
		mb_idx_r == $past(mb_idx_r))
		else $error("index moved mid record");
	base_offset_a: assert property (
		take |=>
		mem_addr_o == $past(base_r) + $past(rec_off))
		else $error("base offset wrong");
	dc_field_a: assert property (
		take |=>
		mem_data_o[22:17] == $past({mv_layout_format_i, coded_dc_pattern_i}))
		else $error("format or DC field wrong");

	rec_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
		take |=> mem_addr_o == $past(base_r) + ($past(mb_idx_r) << 6)) else $error("record address wrong");
	word0_pack_a: assert property (@(posedge clk_i) disable iff (rst_i)
		take |=> mem_data_o[23] == 1'b0 && mem_data_o[16] == 1'b0 && mem_data_o[7:6] == 2'h0
		&& mem_data_o[31:24] == $past(packed_mv_count_i)) else $error("word 0 packing wrong");
	word0_flags_a: assert property (@(posedge clk_i) disable iff (rst_i)
		take |=> mem_data_o[15:13] == $past({xform_size_flag_i, field_mb_flag_i, intra_flag_i})
		&& mem_data_o[12:8] == $past(mb_type_short_i)) else $error("word 0 flags wrong");
	word0_kind_a: assert property (@(posedge clk_i) disable iff (rst_i)
		take |=> mem_data_o[5:4] == $past(intra_mb_kind_i)) else $error("intra kind wrong");
	raster_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
		last |=> mb_idx_r == $past(mb_idx_r) + 32'h1) else $error("index did not step");
	fixed_size_a: assert property (@(posedge clk_i) disable iff (rst_i)
		last |-> mem_addr_o == base_r + rec_off + 32'h3C) else $error("record size wrong");
	no_take_busy_a: assert property (@(posedge clk_i) disable iff (rst_i)
		busy |-> !so_ready_o) else $error("accepted while busy");
	avail_map_a: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> {left_row8_avail_o, top_avail_o, chroma_intra_selector_o}
		== {$past(avail_byte_i[7]), $past(avail_byte_i[4]), $past(avail_byte_i[1:0])}) else $error("avail map wrong");
	pred_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
		w4_r[9:8] == 2'h3 && vc1_r |-> subblock_pred_kind_o[2:0] == mbr_pkg::MBR_PM_INTRA) else $error("pred decode wrong");
	bind_idx_a: assert property (@(posedge clk_i) disable iff (rst_i)
		1'b1 |=> list1_bind_index_o[15:12] == $past(inter_w6_i[28:25])) else $error("bind index wrong");
	rec_walk_c: cover property (@(posedge clk_i) disable iff (rst_i) last);
	two_rec_c: cover property (@(posedge clk_i) disable iff (rst_i) last ##[1:40] last);
	stall_c: cover property (@(posedge clk_i) disable iff (rst_i) busy && !mem_ready_i);
	fmt_err_c: cover property (@(posedge clk_i) disable iff (rst_i) fmt_bad);
endmodule
`default_nettype wire

// >>> hw/mbr_pkg.sv
// Package for the macroblock inline record unpack and stream-out pack block.
// Assumes a 32-bit record word path and a 32-bit byte-addressed memory write port.
package mbr_pkg;
	// Intra availability byte
	localparam int AV_LEFT_ROW8   = 7;
	localparam int AV_LEFT_UPPER  = 6;
	localparam int AV_LEFT_LOWER  = 5;
	localparam int AV_TOP         = 4;
	localparam int AV_TOP_RIGHT   = 3;
	localparam int AV_TOP_LEFT    = 2;
	localparam int AV_CHROMA_LSB  = 0;
	// Inter word 4 fields
	localparam int W4_UV_LSB      = 16;
	localparam int W4_PRED_LSB    = 8;
	localparam int W4_SHAPE_LSB   = 0;
	// Reference byte fields
	localparam int REF_FMT_BIT    = 7;
	localparam int REF_BTI_LSB    = 1;
	// Stream-out word 0 fields
	localparam int SO_MVCNT_LSB   = 24;
	localparam int SO_MVFMT_LSB   = 20;
	localparam int SO_DCPAT_LSB   = 17;
	localparam int SO_XFORM_BIT   = 15;
	localparam int SO_FIELD_BIT   = 14;
	localparam int SO_INTRA_BIT   = 13;
	localparam int SO_MBTYPE_LSB  = 8;
	localparam int SO_IMODE_LSB   = 4;
	// Record geometry
	localparam logic [31:0] SO_REC_BYTES = 32'h00000040;
	localparam logic [3:0]  SO_REC_WORDS = 4'hF;
	// Register map
	localparam logic [7:0] REG_CTRL    = 8'h00;
	localparam logic [7:0] REG_BASE    = 8'h04;
	localparam logic [7:0] REG_STATUS  = 8'h08;
	localparam logic [7:0] REG_MBCOUNT = 8'h0C;
	localparam logic [1:0] CTRL_RST    = 2'h0;
	localparam logic [31:0] BASE_RST   = 32'h00000000;
	// Prediction mode codes
	localparam logic [1:0] PM_L0 = 2'h0;
	localparam logic [1:0] PM_L1 = 2'h1;
	localparam logic [1:0] PM_BI = 2'h2;
	localparam logic [1:0] PM_XX = 2'h3;
	typedef enum logic [2:0] {
		MBR_PM_LIST0,
		MBR_PM_LIST1,
		MBR_PM_BI,
		MBR_PM_INTRA,
		MBR_PM_DIRECT
	} mbr_pred_e;
	typedef enum {
		MBR_IDLE,
		MBR_WRITE
	} mbr_state_e;
endpackage
